// ### spc_pkg.sv
/*
  Constants for the serial port control block: register byte addresses,
  field positions, reset values, frame bit positions and bus answers.
  Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
package spc_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h98;
  localparam logic [7:0] ADDR_RATE_CONFIG    = 8'h9C;
  localparam logic [7:0] ADDR_INT_STATUS     = 8'hA0;
  localparam logic [7:0] ADDR_INT_MASK       = 8'hA4;

  // Control and status field positions
  localparam int unsigned BIT_RECEIVE_DONE   = 0;
  localparam int unsigned BIT_TRANSMIT_DONE  = 1;
  localparam int unsigned BIT_RX_NINTH       = 2;
  localparam int unsigned BIT_TX_NINTH       = 3;
  localparam int unsigned BIT_RECEIVE_ENABLE = 4;
  localparam int unsigned BIT_MP_GATE        = 5;
  localparam int unsigned BIT_MODE_LOW       = 6;
  localparam int unsigned BIT_MODE_HIGH      = 7;

  // Interrupt status and mask field positions
  localparam int unsigned INT_TX_DONE = 0;
  localparam int unsigned INT_RX_DONE = 1;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic       DIV64_RESET   = 1'b0;
  localparam logic [1:0] MASK_RESET    = 2'h0;

  // Frame bit positions, counted from the first data bit as 0
  localparam logic [3:0] IDX_EIGHTH_DATA = 4'h7;
  localparam logic [3:0] IDX_STOP_8BIT   = 4'h8;
  localparam logic [3:0] IDX_NINTH_DATA  = 4'h8;
  localparam logic [3:0] IDX_STOP_9BIT   = 4'h9;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Clock
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Operating modes, encoded as the two mode-select bits
  typedef enum logic [1:0] {
    SPC_MODE_SHIFT = 2'h0,
    SPC_MODE_UART8 = 2'h1,
    SPC_MODE_FIXED = 2'h2,
    SPC_MODE_UART9 = 2'h3
  } spc_mode_e;

endpackage : spc_pkg

// ### spc_sticky_flag.sv
/*
  One sticky flag bit: set by a hardware event, cleared by a bus clear
  or loaded by a bus write. The hardware set always wins.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module spc_sticky_flag (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set,
  input  wire logic clear,
  input  wire logic load,
  input  wire logic load_value,
  output var  logic flag
);

  logic next_flag;

  // Set beats load and clear
  assign next_flag = set | (load ? load_value : (flag & ~clear));

  // Flag storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : spc_sticky_flag

`default_nettype wire

// ### spc_serial_port_control.sv
/*
  Control and status logic of a multifunction serial port, reached over
  AXI4-Lite. Holds mode select, multiprocessor gate, receive enable,
  ninth bits and the done flags, plus an interrupt status and mask.
  Assumes an external shift datapath that pulses one strobe per bit
  shifted, with the bit position counted from the first data bit as 0.
//
// Summary of operation
// - Mode-select 0,0 gives the 8-bit shift register I/O mode.
// - Mode-select 0,1 gives 8-bit asynchronous mode, variable baud rate.
// - Mode-select 1,0 is 9-bit at 1/32 or 1/64 oscillator; 1,1 variable.
// - Shift mode sets transmit-done after the eighth data bit goes out.
// - Asynchronous modes set transmit-done after the frame's last bit.
// - Modes 2 and 3 store the received ninth bit in receive-ninth-bit.
// - Mode 1 with gate clear stores the stop bit in receive-ninth-bit.
// - Receive-ninth-bit carries no meaning in shift mode.
// - Modes 2, 3 with gate set: ninth bit 0 leaves receive-done clear.
// - Mode 1 with gate set: receive-done depends on the stop bit.
*/
`timescale 1ns/1ps
`default_nettype none

module spc_serial_port_control
  import spc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  // AXI4-Lite read data
  output var  logic [DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Shift datapath status
  input  wire logic              tx_bit_strobe,
  input  wire logic [3:0]        tx_bit_index,
  input  wire logic              rx_bit_strobe,
  input  wire logic [3:0]        rx_bit_index,
  input  wire logic              rx_bit_value,
  // Shift datapath control
  output var  logic [1:0]        mode_select,
  output var  logic              nine_bit_frame,
  output var  logic              fixed_rate_div64,
  output var  logic              receive_enable,
  output var  logic              transmit_ninth_bit,
  // Interrupt
  output var  logic              irq
);

  // Held write address and data
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              w_held;

  // Control register fields
  logic       mode_select_high;
  logic       mode_select_low;
  logic       multiprocessor_gate;
  logic       receive_ninth_bit;
  logic       transmit_done_flag;
  logic       receive_done_flag;
  logic       rx_ninth_pending;
  logic [1:0] int_status;
  logic [1:0] int_mask;
  spc_mode_e  mode;

  // Bus handshakes and decode
  wire aw_take    = s_axi_awvalid & s_axi_awready;
  wire w_take     = s_axi_wvalid & s_axi_wready;
  wire ar_take    = s_axi_arvalid & s_axi_arready;
  wire wr_commit  = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctl     = wr_commit & w_lane0 & (aw_addr == ADDR_CONTROL_STATUS);
  wire wr_rate    = wr_commit & w_lane0 & (aw_addr == ADDR_RATE_CONFIG);
  wire wr_mask    = wr_commit & w_lane0 & (aw_addr == ADDR_INT_MASK);
  wire wr_mapped  = (aw_addr == ADDR_CONTROL_STATUS) |
                    (aw_addr == ADDR_RATE_CONFIG) |
                    (aw_addr == ADDR_INT_STATUS) |
                    (aw_addr == ADDR_INT_MASK);
  wire rd_ctl     = s_axi_araddr == ADDR_CONTROL_STATUS;
  wire rd_rate    = s_axi_araddr == ADDR_RATE_CONFIG;
  wire rd_status  = s_axi_araddr == ADDR_INT_STATUS;
  wire rd_mask    = s_axi_araddr == ADDR_INT_MASK;
  wire rd_mapped  = rd_ctl | rd_rate | rd_status | rd_mask;
  wire rd_clear   = ar_take & rd_status;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // mode decode from the two select bits
  assign mode = spc_mode_e'({mode_select_high, mode_select_low});
  assign mode_select = {mode_select_high, mode_select_low};
  // nine-bit frame in modes 2 and 3
  assign nine_bit_frame = mode_select_high;

  wire is_shift = (mode == SPC_MODE_SHIFT);
  wire is_uart8 = (mode == SPC_MODE_UART8);

  // transmit done at eighth bit in shift mode
  wire tx_done_shift = tx_bit_strobe & is_shift &
                       (tx_bit_index == IDX_EIGHTH_DATA);
  // transmit done at stop bit otherwise
  wire tx_done_uart8 = tx_bit_strobe & is_uart8 &
                       (tx_bit_index == IDX_STOP_8BIT);
  wire tx_done_uart9 = tx_bit_strobe & nine_bit_frame &
                       (tx_bit_index == IDX_STOP_9BIT);
  wire tx_done_event = tx_done_shift | tx_done_uart8 | tx_done_uart9;

  // bits only count while reception is enabled
  wire rx_strobe = rx_bit_strobe & receive_enable;
  // shift mode receive end at eighth bit
  wire rx_end_shift = rx_strobe & is_shift &
                      (rx_bit_index == IDX_EIGHTH_DATA);
  wire rx_stop8     = rx_strobe & is_uart8 &
                      (rx_bit_index == IDX_STOP_8BIT);
  wire rx_ninth_cap = rx_strobe & nine_bit_frame &
                      (rx_bit_index == IDX_NINTH_DATA);
  wire rx_stop9     = rx_strobe & nine_bit_frame &
                      (rx_bit_index == IDX_STOP_9BIT);
  // gate set in mode 1 needs a stop bit of 1
  wire rx_ok8 = rx_stop8 & (~multiprocessor_gate | rx_bit_value);
  // gate set in modes 2, 3 needs a ninth bit of 1
  wire rx_ok9 = rx_stop9 & (~multiprocessor_gate | rx_ninth_pending);
  wire rx_done_event = rx_end_shift | rx_ok8 | rx_ok9;

  // mode 1 stop bit into ninth field when gate clear
  wire rb8_load_stop  = rx_stop8 & ~multiprocessor_gate;
  // ninth data bit into ninth field at frame end
  wire rb8_load_ninth = rx_stop9;

  // Held write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held <= 1'b0;
    end
  end

  // Held write data, low byte only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (w_take) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_commit) begin
      w_held <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software-owned control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_select_high    <= CONTROL_RESET[BIT_MODE_HIGH];
      mode_select_low     <= CONTROL_RESET[BIT_MODE_LOW];
      multiprocessor_gate <= CONTROL_RESET[BIT_MP_GATE];
      receive_enable      <= CONTROL_RESET[BIT_RECEIVE_ENABLE];
      transmit_ninth_bit  <= CONTROL_RESET[BIT_TX_NINTH];
    end else if (wr_ctl) begin
      mode_select_high    <= w_byte[BIT_MODE_HIGH];
      mode_select_low     <= w_byte[BIT_MODE_LOW];
      multiprocessor_gate <= w_byte[BIT_MP_GATE];
      receive_enable      <= w_byte[BIT_RECEIVE_ENABLE];
      transmit_ninth_bit  <= w_byte[BIT_TX_NINTH];
    end
  end

  // received ninth bit; left untouched in shift mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_ninth_bit <= CONTROL_RESET[BIT_RX_NINTH];
      rx_ninth_pending  <= 1'b0;
    end else begin
      if (rx_ninth_cap) begin
        rx_ninth_pending <= rx_bit_value;
      end
      if (rb8_load_ninth) begin
        receive_ninth_bit <= rx_ninth_pending;
      end else if (rb8_load_stop) begin
        receive_ninth_bit <= rx_bit_value;
      end else if (wr_ctl) begin
        receive_ninth_bit <= w_byte[BIT_RX_NINTH];
      end
    end
  end

  // Rate divider select for mode 2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fixed_rate_div64 <= DIV64_RESET;
    end else if (wr_rate) begin
      fixed_rate_div64 <= w_byte[0];
    end
  end

  // Interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask <= MASK_RESET;
    end else if (wr_mask) begin
      int_mask <= w_byte[1:0];
    end
  end

  // done flags change only by hardware set or software write
  spc_sticky_flag u_transmit_done (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set        (tx_done_event),
    .clear      (1'b0),
    .load       (wr_ctl),
    .load_value (w_byte[BIT_TRANSMIT_DONE]),
    .flag       (transmit_done_flag)
  );

  spc_sticky_flag u_receive_done (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set        (rx_done_event),
    .clear      (1'b0),
    .load       (wr_ctl),
    .load_value (w_byte[BIT_RECEIVE_DONE]),
    .flag       (receive_done_flag)
  );

  // Interrupt status bits, cleared by reading them
  spc_sticky_flag u_int_tx (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set        (tx_done_event),
    .clear      (rd_clear),
    .load       (1'b0),
    .load_value (1'b0),
    .flag       (int_status[INT_TX_DONE])
  );

  spc_sticky_flag u_int_rx (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set        (rx_done_event),
    .clear      (rd_clear),
    .load       (1'b0),
    .load_value (1'b0),
    .flag       (int_status[INT_RX_DONE])
  );

  // Level interrupt from unmasked status
  assign irq = |(int_status & int_mask);

  // Read data selection
  wire [7:0] ctl_view = {mode_select_high, mode_select_low,
                         multiprocessor_gate, receive_enable,
                         transmit_ninth_bit, receive_ninth_bit,
                         transmit_done_flag, receive_done_flag};
  wire [7:0] rd_byte  = rd_ctl    ? ctl_view :
                        rd_rate   ? {7'h00, fixed_rate_div64} :
                        rd_status ? {6'h00, int_status} :
                        rd_mask   ? {6'h00, int_mask} : 8'h00;

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : spc_serial_port_control

`default_nettype wire

// ### spc_serial_port_control_asserts.sv
/*
  Port checker for the serial port control block.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module spc_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        tx_bit_strobe,
  input wire logic        rx_bit_strobe,
  input wire logic [1:0]  mode_select,
  input wire logic        nine_bit_frame,
  input wire logic        transmit_ninth_bit,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Frame format and control outputs
  a_nine_follows_mode: assert property (
    nine_bit_frame == mode_select[1]) else $error("frame width wrong");
  a_mode_by_write: assert property (
    $changed(mode_select) |-> $rose(s_axi_bvalid))
    else $error("mode moved without write");
  a_ninth_by_write: assert property (
    $changed(transmit_ninth_bit) |-> $rose(s_axi_bvalid))
    else $error("ninth bit moved without write");
  a_irq_has_cause: assert property (
    $rose(irq) |-> $past(tx_bit_strobe) || $past(rx_bit_strobe)
    || $rose(s_axi_bvalid)) else $error("irq rose without event");

  // Register bus answers
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");

  // Main scenarios seen
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : spc_checker

bind spc_serial_port_control spc_checker chk_u (.*);

`default_nettype wire

// ### spc_peer.sv
/*
  Model of the shift datapath: plays one frame of bit strobes.
  Assumes go is a one-cycle pulse while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none

module spc_peer (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic       rx,
  input  wire logic       nine,
  input  wire logic [3:0] last,
  input  wire logic [1:0] gap,
  output var  logic       busy,
  output var  logic       tx_bit_strobe,
  output var  logic [3:0] tx_bit_index,
  output var  logic       rx_bit_strobe,
  output var  logic [3:0] rx_bit_index,
  output var  logic       rx_bit_value
);
  logic [3:0] idx;
  logic [1:0] wait_c;
  logic       dir;

  initial begin
    {busy, tx_bit_strobe, rx_bit_strobe, rx_bit_value} = 4'h0;
    {tx_bit_index, rx_bit_index, idx, wait_c, dir} = 15'h0000;
  end

  // One strobe per bit, gap idle cycles apart
  always @(posedge aclk) begin
    tx_bit_strobe <= 1'b0;
    rx_bit_strobe <= 1'b0;
    rx_bit_value  <= ~rx_bit_value; // Released line toggles
    if (go) begin
      {busy, idx, wait_c, dir} <= {1'b1, 4'h0, gap, rx};
    end else if (busy && wait_c != 2'h0) begin
      wait_c <= wait_c - 2'h1;
    end else if (busy) begin
      // bits in frame order; index 8 carries nine, later bits high
      tx_bit_strobe <= !dir;
      rx_bit_strobe <= dir;
      tx_bit_index  <= idx;
      rx_bit_index  <= idx;
      rx_bit_value  <= (idx == 4'h8) ? nine : (idx > 4'h8) | idx[0];
      wait_c        <= gap;
      idx           <= idx + 4'h1;
      busy          <= (idx != last);
    end
  end
endmodule : spc_peer

`default_nettype wire

// ### spc_serial_port_control_bench.sv
/*
  Self-checking bench for the serial port control block.
  Assumes the shift datapath model drives the bit strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module spc_serial_port_control_bench;
  import spc_pkg::*;
  logic              aclk, aresetn, go, rx, nine, busy, slow, irq;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, rdat;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, tx_bit_index, rx_bit_index, last;
  logic [1:0]        s_axi_bresp, s_axi_rresp, mode_select, gap, resp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, tx_bit_strobe, rx_bit_strobe;
  logic              rx_bit_value, nine_bit_frame, fixed_rate_div64;
  logic              receive_enable, transmit_ninth_bit;
  int                failures, samples_checked;

  spc_serial_port_control dut_u (.*);
  spc_peer peer_u (.*);

  // Clock of 8 ns
  initial aclk = 1'b0;
  always #(CLK_PERIOD_NS / 2) aclk = ~aclk;

  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    logic aw, w;
    int   n;
    {aw, w, n} = {2'b11, 32'd0};
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'b11, !slow};
    do begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && ++n < 60);
    chk("bus_wait", n < 60, 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    @(posedge aclk); // Gap before the next request
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= {1'b1, !slow};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && ++n < 60);
    chk("bus_wait", n < 60, 1'b1);
    s_axi_rready <= 1'b0;
    {rdat, resp} = {s_axi_rdata[7:0], s_axi_rresp};
    @(posedge aclk); // Gap before the next request
  endtask : rd

  task automatic rc(input logic [7:0] a, e);
    rd(a);
    chk($sformatf("reg_%h", a), rdat, e);
  endtask : rc

  task automatic frame(input logic r, input logic [3:0] l, input logic v);
    int n;
    n = 0;
    {rx, last, nine, go} <= {r, l, v, 1'b1};
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy && ++n < 100);
    chk("frame_wait", n < 100, 1'b1);
    @(posedge aclk);
  endtask : frame

  task automatic t_reset;
    rc(ADDR_CONTROL_STATUS, CONTROL_RESET);
    rc(ADDR_RATE_CONFIG, 8'h00);
    rc(ADDR_INT_MASK, 8'h00);
    rc(8'h80, 8'h00);
    chk("rresp", resp, RESP_SLVERR);
    wr(8'h80, 8'h00);
    chk("bresp", resp, RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    wr(ADDR_CONTROL_STATUS, 8'hFF);
    chk("bresp_ok", resp, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rc(ADDR_CONTROL_STATUS, CONTROL_RESET);
    $display("done t_reset");
  endtask : t_reset

  task automatic t_modes;
    slow = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CONTROL_STATUS, {m[1:0], 6'h08});
      chk("mode", mode_select, m[1:0]);
      chk("nine", nine_bit_frame, m[1]);
      chk("tb8", transmit_ninth_bit, 1'b1);
      rc(ADDR_CONTROL_STATUS, {m[1:0], 6'h08});
    end
    wr(ADDR_RATE_CONFIG, 8'h01);
    chk("div64", fixed_rate_div64, 1'b1);
    slow = 1'b0;
    $display("done t_modes");
  endtask : t_modes

  task automatic t_tx;
    logic [3:0] l;
    for (int m = 0; m < 4; m++) begin
      l = (m == 0) ? 4'h7 : (m == 1) ? 4'h8 : 4'h9;
      gap <= m[1:0];
      wr(ADDR_CONTROL_STATUS, {m[1:0], 6'h00});
      frame(1'b0, l - 4'h1, 1'b0);
      rc(ADDR_CONTROL_STATUS, {m[1:0], 6'h00});
      frame(1'b0, l, 1'b0);
      rc(ADDR_CONTROL_STATUS, {m[1:0], 6'h02});
    end
    $display("done t_tx");
  endtask : t_tx

  task automatic t_rx;
    logic [7:0] c;
    logic [7:0] tab [10] = '{8'h19, 8'h08, 8'h5B, 8'h55, 8'h76,
                             8'h79, 8'h95, 8'hF4, 8'hFB, 8'h88};
    for (int i = 0; i < 10; i++) begin
      c = tab[i];
      gap <= i[1:0];
      wr(ADDR_CONTROL_STATUS, {c[7:4], 1'b0, c[2], 2'b00});
      chk("ren", receive_enable, c[4]);
      frame(1'b1, (c[7:6] == 2'h0) ? 4'h7 : 4'h8 + {3'h0, c[7]}, c[3]);
      rc(ADDR_CONTROL_STATUS, {c[7:4], 1'b0, c[1], 1'b0, c[0]});
    end
    $display("done t_rx");
  endtask : t_rx

  task automatic t_irq;
    wr(ADDR_CONTROL_STATUS, 8'hD0);
    rd(ADDR_INT_STATUS);
    frame(1'b0, 4'h9, 1'b0);
    chk("irq_masked", irq, 1'b0);
    wr(ADDR_INT_MASK, 8'h03);
    chk("irq_on", irq, 1'b1);
    rc(ADDR_INT_STATUS, 8'h01);
    @(posedge aclk);
    chk("irq_off", irq, 1'b0);
    rc(ADDR_CONTROL_STATUS, 8'hD2);
    frame(1'b1, 4'h9, 1'b1);
    chk("irq_rx", irq, 1'b1);
    rc(ADDR_INT_STATUS, 8'h02);
    rc(ADDR_CONTROL_STATUS, 8'hD7);
    wr(ADDR_CONTROL_STATUS, 8'hD0);
    rc(ADDR_CONTROL_STATUS, 8'hD0);
    $display("done t_irq");
  endtask : t_irq

  // Reset, then the scenarios
  initial begin
    {aresetn, slow, go, rx, nine, last, gap} = 11'h000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0F;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_modes;
    t_tx;
    t_rx;
    t_irq;
    end_sim;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_sim;
  end
endmodule : spc_serial_port_control_bench

`default_nettype wire
